// >>> inc/sacc_defs.vh
// Purpose: Offsets, field positions and reset values of the converter control block
// Assumes: Register byte address is four times the register index
// Notes:   Definitions only
`ifndef SACC_DEFS_VH
`define SACC_DEFS_VH

// Register indices
`define SACC_IDX_CTRL_STAT    14'h0010
`define SACC_IDX_TRIG_CMP     14'h0011
`define SACC_IDX_CLK_RES      14'h0012
`define SACC_IDX_FIFO_DEPTH   14'h0013
`define SACC_IDX_RES_HIGH     14'h0014
`define SACC_IDX_RES_LOW      14'h0015
`define SACC_IDX_CMP_HIGH     14'h0016
`define SACC_IDX_CMP_LOW      14'h0017
`define SACC_IDX_IRQ_STAT     14'h0018
`define SACC_IDX_IRQ_MASK     14'h0019
`define SACC_IDX_PIN_DIS_LO   14'h30AC
`define SACC_IDX_PIN_DIS_HI   14'h30AD

// Reset values
`define SACC_RST_CTRL_STAT    8'h1F
`define SACC_RST_TRIG_CMP     8'h08
`define SACC_RST_ZERO         8'h00

// Control/status fields
`define SACC_CS_FLAG          7
`define SACC_CS_IRQ_EN        6
`define SACC_CS_CONT          5
`define SACC_CS_CH_HI         4
`define SACC_CH_OFF           5'h1F

// Trigger/compare fields
`define SACC_TC_ACTIVE        7
`define SACC_TC_TRIG          6
`define SACC_TC_CMP_EN        5
`define SACC_TC_CMP_GT        4
`define SACC_TC_EMPTY         3
`define SACC_TC_FULL          2

// Queue depth field top bit
`define SACC_QD_HI            2

// Interrupt status bits
`define SACC_IRQ_FLAG         0
`define SACC_IRQ_DONE         1

`endif

// >>> src/sacc_ctrl.v
// Purpose: Conversion control of a 10-bit successive approximation converter behind APB
// Assumes: Converter core runs on core_clk_i; done is a one-cycle pulse with result valid
// Notes:   APB answers one cycle into the access phase
// Summary of operation
// - A write to the control/status register aborts a running conversion and, with the queue off, starts a new one unless the channel is all ones.
// - With the queue enabled each channel write is pushed into the channel queue, until it holds one more entry than the depth, instead of selecting one channel.
// - Queued channels are converted in the order they were written.
// - In queue mode conversion waits until the queue holds one more entry than the programmed depth.
// - Writing channel 0x1F empties the queue and halts any active conversion.
// - With compare off and the queue off the complete flag in bit 7 is set at the end of every conversion.
// - With compare on the complete flag is set only when the compare condition holds for the result, or in queue mode for any result of the set.
// - With queue depth above 0 the complete flag is set only when the whole queued set finishes.
// - The complete flag clears on a control/status write or a low result byte read.
// - The interrupt is raised when the complete flag is set while the enable in bit 6 is high.
// - The selected channel code is routed to the converter, covering up to 31 inputs.
// - The channel field is 5 bits and all ones means the converter is disabled and idle.
// - With continuous mode set a start repeats conversions back to back until stopped.
// - The active bit rises when a conversion starts and falls when the last conversion completes outside continuous mode or is aborted.
//
// The APB register port was decided locally.
`timescale 1ns/100ps
`include "sacc_defs.vh"

module sacc_ctrl #(
  parameter QDEPTH = 8,
  parameter RES_W  = 10
) (
  input  wire             core_clk_i,
  input  wire             nrst_i,
  input  wire             psel_i,
  input  wire             penable_i,
  input  wire             pwrite_i,
  input  wire [15:0]      paddr_i,
  input  wire [31:0]      pwdata_i,
  input  wire [3:0]       pstrb_i,
  output wire [31:0]      prdata_o,
  output wire             pready_o,
  output wire             pslverr_o,
  output wire [4:0]       chan_sel_o,
  output wire             conv_start_o,
  output wire             conv_abort_o,
  input  wire             conv_done_i,
  input  wire [RES_W-1:0] conv_result_i,
  output wire [15:0]      pin_dis_o,
  output wire             irq_o
);

  reg [31:0]      prdata_r;
  reg             pready_r;
  reg             pslverr_r;
  reg [4:0]       chan_r;
  reg             conv_start_r;
  reg             conv_abort_r;
  reg             irq_r;
  reg             done_flag_r;
  reg             irq_en_r;
  reg             cont_mode_r;
  reg [4:0]       chan_field_r;
  reg             active_r;
  reg             adtrg_r;
  reg             cmp_en_r;
  reg             acfgt_r;
  reg [1:0]       refsel_r;
  reg [7:0]       clk_res_r;
  reg [7:0]       fifo_cfg_r;
  reg [RES_W-1:0] res_r;
  reg [1:0]       cvh_r;
  reg [7:0]       cvl_r;
  reg [7:0]       pin_lo_r;
  reg [7:0]       pin_hi_r;
  reg [1:0]       irq_stat_r;
  reg [1:0]       irq_mask_r;
  // Queue storage, written only while filling
  reg [4:0]       qmem [0:QDEPTH-1];
  reg [3:0]       qcnt_r;
  reg [2:0]       qidx_r;
  reg             qhit_r;
  reg [31:0]      rd_nxt;
  reg             err_nxt;
  reg             done_flag_nxt;

  // Register decode
  wire [13:0]      idx      = paddr_i[15:2];
  wire             acc      = psel_i & penable_i & pready_r;
  wire             wr       = acc & pwrite_i & pstrb_i[0] & (paddr_i[1:0] == 2'b00);
  wire             rd       = acc & ~pwrite_i & (paddr_i[1:0] == 2'b00);
  wire [7:0]       wdat     = pwdata_i[7:0];
  wire             cs_wr    = wr & (idx == `SACC_IDX_CTRL_STAT);
  wire             rl_rd    = rd & (idx == `SACC_IDX_RES_LOW);
  wire             st_wr    = wr & (idx == `SACC_IDX_IRQ_STAT);
  wire [2:0]       qdep     = fifo_cfg_r[`SACC_QD_HI:0];
  wire             fifo_en  = (qdep != 3'h0);
  wire [3:0]       qneed    = {1'b0, qdep} + 4'h1;
  wire [RES_W-1:0] cv       = {cvh_r, cvl_r};
  // Done pulses count only while active
  wire             done_v   = conv_done_i & active_r;
  wire             hit      = cmp_true(conv_result_i, cv, acfgt_r);
  wire             q_last   = ({1'b0, qidx_r} == (qcnt_r - 4'h1));
  wire             q_empty  = (qcnt_r == 4'h0);
  wire             q_full   = fifo_en & (qcnt_r == qneed);
  wire [4:0]       new_ch   = wdat[`SACC_CS_CH_HI:0];
  wire [2:0]       qnext    = qidx_r + 3'h1;

  // Compare condition: greater or equal, else less than
  function cmp_true;
    input [RES_W-1:0] res;
    input [RES_W-1:0] lim;
    input             gt;
    begin
      cmp_true = gt ? (res >= lim) : (res < lim);
    end
  endfunction

  // Complete flag set condition per conversion or per queued set
  wire flag_set = done_v & (fifo_en ? (q_last & (~cmp_en_r | hit | qhit_r))
                                    : (~cmp_en_r | hit));

  always @* begin
    done_flag_nxt = done_flag_r;
    if (cs_wr | rl_rd) begin
      done_flag_nxt = 1'b0;
    end
    if (flag_set) begin
      done_flag_nxt = 1'b1;
    end
  end

  // Read multiplexer and unmapped-address decode
  always @* begin
    rd_nxt  = 32'h0000_0000;
    err_nxt = 1'b0;
    if (paddr_i[1:0] != 2'b00) begin
      err_nxt = 1'b1;
    end else begin
      case (idx)
        `SACC_IDX_CTRL_STAT: begin
          rd_nxt[7:0] = {done_flag_r, irq_en_r, cont_mode_r, chan_field_r};
        end
        `SACC_IDX_TRIG_CMP: begin
          rd_nxt[7:0] = {active_r, adtrg_r, cmp_en_r, acfgt_r, q_empty, q_full, refsel_r};
        end
        `SACC_IDX_CLK_RES: begin
          rd_nxt[7:0] = clk_res_r;
        end
        `SACC_IDX_FIFO_DEPTH: begin
          rd_nxt[7:0] = fifo_cfg_r;
        end
        `SACC_IDX_RES_HIGH: begin
          rd_nxt[1:0] = res_r[RES_W-1:8];
        end
        `SACC_IDX_RES_LOW: begin
          rd_nxt[7:0] = res_r[7:0];
        end
        `SACC_IDX_CMP_HIGH: begin
          rd_nxt[1:0] = cvh_r;
        end
        `SACC_IDX_CMP_LOW: begin
          rd_nxt[7:0] = cvl_r;
        end
        `SACC_IDX_IRQ_STAT: begin
          rd_nxt[1:0] = irq_stat_r;
        end
        `SACC_IDX_IRQ_MASK: begin
          rd_nxt[1:0] = irq_mask_r;
        end
        `SACC_IDX_PIN_DIS_LO: begin
          rd_nxt[7:0] = pin_lo_r;
        end
        `SACC_IDX_PIN_DIS_HI: begin
          rd_nxt[7:0] = pin_hi_r;
        end
        default: begin
          err_nxt = 1'b1;
        end
      endcase
    end
  end

  // APB handshake, one wait state
  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= psel_i & penable_i & ~pready_r;
      pslverr_r <= psel_i & penable_i & ~pready_r & err_nxt;
      prdata_r  <= (psel_i & penable_i & ~pready_r & ~pwrite_i) ? rd_nxt : 32'h0000_0000;
    end
  end

  // Plain configuration registers
  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      adtrg_r    <= 1'b0;
      cmp_en_r   <= 1'b0;
      acfgt_r    <= 1'b0;
      refsel_r   <= 2'b00;
      clk_res_r  <= `SACC_RST_ZERO;
      fifo_cfg_r <= `SACC_RST_ZERO;
      cvh_r      <= 2'b00;
      cvl_r      <= `SACC_RST_ZERO;
      pin_lo_r   <= `SACC_RST_ZERO;
      pin_hi_r   <= `SACC_RST_ZERO;
      irq_mask_r <= 2'b00;
    end else if (wr) begin
      case (idx)
        `SACC_IDX_TRIG_CMP: begin
          adtrg_r  <= wdat[`SACC_TC_TRIG];
          cmp_en_r <= wdat[`SACC_TC_CMP_EN];
          acfgt_r  <= wdat[`SACC_TC_CMP_GT];
          refsel_r <= wdat[1:0];
        end
        `SACC_IDX_CLK_RES: begin
          clk_res_r <= wdat;
        end
        `SACC_IDX_FIFO_DEPTH: begin
          fifo_cfg_r <= wdat;
        end
        `SACC_IDX_CMP_HIGH: begin
          cvh_r <= wdat[1:0];
        end
        `SACC_IDX_CMP_LOW: begin
          cvl_r <= wdat;
        end
        `SACC_IDX_PIN_DIS_LO: begin
          pin_lo_r <= wdat;
        end
        `SACC_IDX_PIN_DIS_HI: begin
          pin_hi_r <= wdat;
        end
        `SACC_IDX_IRQ_MASK: begin
          irq_mask_r <= wdat[1:0];
        end
        default: begin
          irq_mask_r <= irq_mask_r;
        end
      endcase
    end
  end

  // Sticky interrupt status, set wins over write-one-to-clear
  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      irq_stat_r <= 2'b00;
      irq_r      <= 1'b0;
    end else begin
      irq_stat_r[`SACC_IRQ_FLAG] <= flag_set |
        (irq_stat_r[`SACC_IRQ_FLAG] & ~(st_wr & wdat[`SACC_IRQ_FLAG]));
      irq_stat_r[`SACC_IRQ_DONE] <= done_v |
        (irq_stat_r[`SACC_IRQ_DONE] & ~(st_wr & wdat[`SACC_IRQ_DONE]));
      irq_r <= (done_flag_r & irq_en_r) | (|(irq_stat_r & irq_mask_r));
    end
  end

  // Conversion sequencing and channel queue
  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      done_flag_r  <= 1'b0;
      irq_en_r     <= 1'b0;
      cont_mode_r  <= 1'b0;
      chan_field_r <= `SACC_CH_OFF;
      active_r     <= 1'b0;
      chan_r       <= `SACC_CH_OFF;
      conv_start_r <= 1'b0;
      conv_abort_r <= 1'b0;
      res_r        <= {RES_W{1'b0}};
      qcnt_r       <= 4'h0;
      qidx_r       <= 3'h0;
      qhit_r       <= 1'b0;
    end else begin
      done_flag_r  <= done_flag_nxt;
      conv_start_r <= 1'b0;
      conv_abort_r <= 1'b0;
      if (done_v) begin
        res_r <= conv_result_i;
      end
      if (cs_wr) begin
        irq_en_r     <= wdat[`SACC_CS_IRQ_EN];
        cont_mode_r  <= wdat[`SACC_CS_CONT];
        chan_field_r <= new_ch;
        conv_abort_r <= active_r & ~done_v;
        active_r     <= 1'b0;
        if (new_ch == `SACC_CH_OFF) begin
          qcnt_r <= 4'h0;
          qidx_r <= 3'h0;
          chan_r <= `SACC_CH_OFF;
        end else if (fifo_en) begin
          // Queue filling
          if (qcnt_r < qneed) begin
            qmem[qcnt_r[2:0]] <= new_ch;
            qcnt_r            <= qcnt_r + 4'h1;
          end
          if ((qcnt_r + 4'h1) >= qneed) begin
            chan_r       <= q_empty ? new_ch : qmem[0];
            conv_start_r <= 1'b1;
            active_r     <= 1'b1;
            qidx_r       <= 3'h0;
            qhit_r       <= 1'b0;
          end
        end else begin
          chan_r       <= new_ch;
          conv_start_r <= 1'b1;
          active_r     <= 1'b1;
        end
      end else if (done_v) begin
        if (fifo_en) begin
          if (q_last) begin
            qidx_r <= 3'h0;
            qhit_r <= 1'b0;
            if (cont_mode_r) begin
              chan_r       <= qmem[0];
              conv_start_r <= 1'b1;
            end else begin
              active_r <= 1'b0;
              qcnt_r  <= 4'h0;
            end
          end else begin
            qidx_r       <= qnext;
            qhit_r       <= qhit_r | hit;
            chan_r       <= qmem[qnext];
            conv_start_r <= 1'b1;
          end
        end else if (cont_mode_r) begin
          conv_start_r <= 1'b1;
        end else begin
          active_r <= 1'b0;
        end
      end
    end
  end

  // Output drives
  assign prdata_o     = prdata_r;
  assign pready_o     = pready_r;
  assign pslverr_o    = pslverr_r;
  assign chan_sel_o   = chan_r;
  assign conv_start_o = conv_start_r;
  assign conv_abort_o = conv_abort_r;
  assign pin_dis_o    = {pin_hi_r, pin_lo_r};
  assign irq_o        = irq_r;

endmodule

// >>> verif/sacc_core_model.sv
// Purpose: Behavioural converter core answering start and abort
// Assumes: Done is a one-cycle pulse with the result valid beside it
// Notes:   Result is the channel code twice; it wanders outside done
`timescale 1ns/100ps
module sacc_core_model #(
  parameter LAT = 12
) (
  input  wire       core_clk_i,
  input  wire       nrst_i,
  input  wire [4:0] chan_sel_i,
  input  wire       conv_start_i,
  input  wire       conv_abort_i,
  output reg        conv_done_o,
  output reg  [9:0] conv_result_o
);
  reg [7:0] cnt_r;
  reg [4:0] ch_r;
  always @(posedge core_clk_i) begin
    conv_done_o   <= 1'b0;
    conv_result_o <= conv_result_o ^ 10'h15A;
    if (!nrst_i) begin
      cnt_r         <= 8'h00;
      conv_result_o <= 10'h155;
    end else if (conv_start_i) begin
      cnt_r <= LAT[7:0];
      ch_r  <= chan_sel_i;
    end else if (conv_abort_i) begin
      cnt_r <= 8'h00;
    end else if (cnt_r == 8'h01) begin
      cnt_r         <= 8'h00;
      conv_done_o   <= 1'b1;
      conv_result_o <= {ch_r, ch_r};
    end else if (cnt_r != 8'h00) begin
      cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule

// >>> verif/sacc_ctrl_sva.sv
// Purpose: Port checks of the converter control block
// Assumes: Byte address is four times the register index
// Notes:   Bound from the testbench file
`timescale 1ns/100ps
module sacc_ctrl_sva (
  input wire        core_clk_i,
  input wire        nrst_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [15:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0]  pstrb_i,
  input wire        pready_o,
  input wire        pslverr_o,
  input wire [4:0]  chan_sel_o,
  input wire        conv_start_o,
  input wire        conv_abort_o,
  input wire        conv_done_i,
  input wire        irq_o
);
  wire       wr    = psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0] && !pslverr_o;
  wire       wr_cs = wr && paddr_i == 16'h0040;
  wire       off   = pwdata_i[4:0] == 5'h1F;
  reg  [2:0] dep_r;
  reg  [3:0] q_r;
  reg        busy_r;
  // Writes since the last clear; never below the real queue count
  always @(posedge core_clk_i) begin
    if (!nrst_i) begin
      dep_r  <= 3'h0;
      q_r    <= 4'h0;
      busy_r <= 1'b0;
    end else begin
      if (wr && paddr_i == 16'h004C)
        dep_r <= pwdata_i[2:0];
      if (wr_cs)
        q_r <= off ? 4'h0 : q_r + {3'h0, q_r != 4'hF};
      busy_r <= conv_start_o || (busy_r && !conv_done_i && !conv_abort_o);
    end
  end
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);
  a_bus_ready: assert property (psel_i && $rose(penable_i) |=> pready_o ##1 !pready_o)
    else $error("ready pulse misplaced");
  a_misalign_err: assert property (psel_i && penable_i && pready_o && paddr_i[1:0] != 2'b00 |-> pslverr_o)
    else $error("misaligned access not refused");
  a_write_starts: assert property (wr_cs && !off && dep_r == 3'h0 |=> conv_start_o && chan_sel_o == $past(pwdata_i[4:0]))
    else $error("write did not start channel");
  a_off_halts: assert property (wr_cs && off |=> !conv_start_o && chan_sel_o == 5'h1F)
    else $error("off code did not halt");
  a_rewrite_aborts: assert property (wr_cs && busy_r && !conv_done_i |=> conv_abort_o)
    else $error("running conversion not aborted");
  a_queue_waits: assert property (wr_cs && dep_r != 3'h0 && !off && q_r < {1'b0, dep_r} |=> !conv_start_o)
    else $error("start before queue filled");
  a_queue_full: assert property (wr_cs && dep_r != 3'h0 && !off && q_r == {1'b0, dep_r} |=> conv_start_o)
    else $error("full queue did not start");
  a_irq_cause: assert property ($rose(irq_o) |-> $past(conv_done_i, 2) || $past(wr && paddr_i == 16'h0064, 2))
    else $error("interrupt without cause");
  a_start_chan: assert property (conv_start_o |-> chan_sel_o != 5'h1F)
    else $error("start on off code");
  c_abort: cover property (wr_cs && busy_r);
  c_irq: cover property ($rose(irq_o));
  c_queue: cover property (wr_cs && dep_r != 3'h0 && q_r == {1'b0, dep_r});
endmodule

// >>> verif/testbench.sv
// Purpose: Register level tests of the converter control block
// Assumes: Core model latency 12 cycles
// Notes:   Byte address is four times the register index
`timescale 1ns/100ps
module testbench;
  logic        core_clk_i = 1'b0;
  logic        nrst_i     = 1'b0;
  logic        psel_i     = 1'b0;
  logic        penable_i  = 1'b0;
  logic        pwrite_i   = 1'b0;
  logic [15:0] paddr_i    = 16'h0000;
  logic [31:0] pwdata_i   = 32'h0000_0000;
  logic [3:0]  pstrb_i    = 4'hF;
  wire  [31:0] prdata_o;
  wire         pready_o, pslverr_o, conv_start_o, conv_abort_o, conv_done_i, irq_o;
  wire  [4:0]  chan_sel_o;
  wire  [9:0]  conv_result_i;
  wire  [15:0] pin_dis_o;
  int          bad_count  = 0;
  int          checked    = 0;
  int          cyc        = 0;
  logic [4:0]  chq[$];
  logic [7:0]  q;
  logic        e;
  sacc_ctrl #(.QDEPTH(8), .RES_W(10)) DUT (.core_clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .pstrb_i, .prdata_o, .pready_o, .pslverr_o, .chan_sel_o, .conv_start_o, .conv_abort_o,
    .conv_done_i, .conv_result_i, .pin_dis_o, .irq_o);
  sacc_core_model #(.LAT(12)) u_core (.core_clk_i, .nrst_i, .chan_sel_i(chan_sel_o), .conv_start_i(conv_start_o),
    .conv_abort_i(conv_abort_o), .conv_done_o(conv_done_i), .conv_result_o(conv_result_i));
  initial forever #5 core_clk_i = ~core_clk_i;
  task wrap_up;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= {24'h0, d};
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    q = prdata_o[7:0];
    e = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(negedge core_clk_i);
  endtask
  task rd(input logic [15:0] a, input logic [7:0] x, input string nm);
    apb(1'b0, a, 8'h00);
    chk(q, x, nm);
  endtask
  task wdone;
    do @(negedge core_clk_i); while (conv_done_i !== 1'b1);
    repeat (3) @(posedge core_clk_i);
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (conv_start_o === 1'b1)
      chq.push_back(chan_sel_o);
    if (cyc == 5000) begin
      bad_count++;
      wrap_up();
    end
  end
  initial begin
    repeat (12) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    rd(16'h0040, 8'h1F, "ctrl reset");
    rd(16'h0044, 8'h08, "trig reset");
    rd(16'h0080, 8'h00, "unmapped");
    chk(e, 1, "unmapped err");
    apb(1'b0, 16'h0041, 8'h00);
    chk(e, 1, "misaligned err");
    apb(1'b1, 16'hC2B0, 8'hA5);
    apb(1'b1, 16'hC2B4, 8'h3C);
    chk(pin_dis_o, 16'h3CA5, "pin disable");
    apb(1'b1, 16'h0040, 8'h43);
    wdone;
    chk(irq_o, 1, "irq");
    chk(chq[$], 3, "channel");
    rd(16'h0040, 8'hC3, "flag set");
    rd(16'h0054, 8'h63, "low result");
    rd(16'h0040, 8'h43, "flag after read");
    chk(irq_o, 0, "irq off");
    apb(1'b1, 16'h0040, 8'h02);
    apb(1'b1, 16'h0040, 8'h05);
    wdone;
    rd(16'h0040, 8'h85, "flag set");
    apb(1'b1, 16'h0040, 8'h9F);
    rd(16'h0040, 8'h1F, "flag after write");
    rd(16'h0054, 8'hA5, "low result");
    apb(1'b1, 16'h0044, 8'h20);
    apb(1'b1, 16'h0040, 8'h03);
    wdone;
    rd(16'h0040, 8'h03, "compare miss");
    apb(1'b1, 16'h0044, 8'h30);
    apb(1'b1, 16'h0040, 8'h03);
    wdone;
    rd(16'h0040, 8'h83, "compare hit");
    apb(1'b1, 16'h0044, 8'h00);
    apb(1'b1, 16'h004C, 8'h01);
    apb(1'b1, 16'h0040, 8'h1F);
    chq.delete();
    apb(1'b1, 16'h0040, 8'h04);
    chk(chq.size(), 0, "queue wait");
    apb(1'b1, 16'h0040, 8'h06);
    wdone;
    rd(16'h0040, 8'h06, "mid set flag");
    wdone;
    rd(16'h0040, 8'h86, "set end flag");
    chk(chq[0], 4, "queue first");
    chk(chq[1], 6, "queue second");
    rd(16'h0054, 8'hC6, "low result");
    apb(1'b1, 16'h004C, 8'h00);
    rd(16'h0060, 8'h03, "irq status");
    apb(1'b1, 16'h0064, 8'h01);
    repeat (2) @(posedge core_clk_i);
    chk(irq_o, 1, "masked irq");
    apb(1'b1, 16'h0060, 8'h03);
    repeat (2) @(posedge core_clk_i);
    chk(irq_o, 0, "irq cleared");
    rd(16'h0060, 8'h00, "status cleared");
    chq.delete();
    apb(1'b1, 16'h0040, 8'h25);
    repeat (3) wdone;
    apb(1'b1, 16'h0040, 8'h1F);
    chk(chq.size(), 4, "repeat starts");
    chk(chq[3], 5, "repeat channel");
    repeat (30) @(posedge core_clk_i);
    chk(chq.size(), 4, "halted");
    chk(chan_sel_o, 5'h1F, "off code");
    wrap_up();
  end
endmodule
bind sacc_ctrl sacc_ctrl_sva u_sva (.core_clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
  .pstrb_i, .pready_o, .pslverr_o, .chan_sel_o, .conv_start_o, .conv_abort_o, .conv_done_i, .irq_o);
